//--- hdl/ptp_regs.svh
// register map, field positions, reset values and counts of the period timer
`ifndef PTP_REGS_SVH
`define PTP_REGS_SVH

// ----------------------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------------------
`define PTP_OFF_COUNT 8'h00
`define PTP_OFF_PERIOD 8'h04
`define PTP_OFF_CTRL 8'h08
`define PTP_OFF_CTRL1 8'h0C
`define PTP_OFF_HALT 8'h10
`define PTP_OFF_RSTSRC 8'h14
`define PTP_OFF_STATUS 8'h18
`define PTP_OFF_MASK 8'h1C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PTP_CTRL_RUN_BIT 7
`define PTP_CTRL_PSC_HI 6
`define PTP_CTRL_PSC_LO 4
`define PTP_ST_PULSE_BIT 0
`define PTP_ST_MATCH_BIT 1
`define PTP_ST_STOP_BIT 2

// ----------------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------------
`define PTP_RST_COUNT 8'h00
`define PTP_RST_PERIOD 8'hFF
`define PTP_RST_MODE 5'h00
`define PTP_RST_POST 5'h00
`define PTP_RST_SRC 3'h0
`define PTP_RST_PSC 3'h0
`define PTP_RST_EVT 3'h0
`define PTP_RESP_OKAY 2'h0
`define PTP_RESP_SLVERR 2'h2
`define PTP_RD_ZERO 32'h0000_0000

// ----------------------------------------------------------------------------
// counts
// ----------------------------------------------------------------------------
`define PTP_PSC_W 7
`define PTP_POST_W 5
`define PTP_SRC_N 8

`endif

//--- hdl/ptp_pkg.sv
// types shared by the period timer modules
package ptp_pkg;

  // --------------------------------------------------------------------------
  // run state of the counter
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_HOLD = 3'h4
  } ptp_state_type;

  // --------------------------------------------------------------------------
  // mode field: family in the top two bits, trigger option below
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FAM_FREE = 2'h0,
    FAM_ONE = 2'h1,
    FAM_MONO = 2'h2,
    FAM_RSVD = 2'h3
  } ptp_family_type;

  typedef enum logic [2:0] {
    OPT_NONE = 3'h0,
    OPT_GATE_HI = 3'h1,
    OPT_GATE_LO = 3'h2,
    OPT_RST_RISE = 3'h3,
    OPT_RST_FALL = 3'h4,
    OPT_RST_EDGE = 3'h5,
    OPT_RST_LOW = 3'h6,
    OPT_RST_HIGH = 3'h7
  } ptp_opt_type;

  typedef struct packed {
    ptp_family_type family;
    ptp_opt_type opt;
  } ptp_mode_type;

  // selected external source: level and one-cycle edges
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } ptp_trig_type;

endpackage

//--- hdl/ptp_prescaler.sv
// programmable prescaler producing the timer tick
`timescale 1ns/1ps
`default_nettype none
`include "ptp_regs.svh"

module ptp_prescaler (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // control
  input wire logic i_clear,
  input wire logic i_run,
  input wire logic [2:0] i_sel,
  // tick out
  output logic o_tick
);

  logic [`PTP_PSC_W-1:0] cnt_reg;
  wire [`PTP_PSC_W:0] ratio = (`PTP_PSC_W+1)'(1) << i_sel;
  wire [`PTP_PSC_W-1:0] last_w = `PTP_PSC_W'(ratio - (`PTP_PSC_W+1)'(1));
  wire hit = (cnt_reg == last_w);

  // divide the core clock by two to the power of the select
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
      o_tick <= 1'b0;
    end else if (i_clear || !i_run) begin
      cnt_reg <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_reg <= hit ? '0 : cnt_reg + `PTP_PSC_W'(1);
      o_tick <= hit;
    end
  end

endmodule
`default_nettype wire

//--- hdl/ptp_trigger.sv
// external source selection with edge detection and debug freeze
`timescale 1ns/1ps
`default_nettype none
`include "ptp_regs.svh"

module ptp_trigger (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // sources and selection
  input wire logic [`PTP_SRC_N-1:0] i_src,
  input wire logic [2:0] i_sel,
  input wire logic i_freeze,
  // selected trigger
  output ptp_pkg::ptp_trig_type o_trig
);

  logic level_reg;
  logic prev_reg;

  // frozen level makes every edge and change invisible
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      level_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      level_reg <= i_freeze ? level_reg : i_src[i_sel];
      prev_reg <= level_reg;
    end
  end

  assign o_trig.level = level_reg;
  assign o_trig.rise = level_reg & ~prev_reg;
  assign o_trig.fall = ~level_reg & prev_reg;

endmodule
`default_nettype wire

//--- hdl/ptp_timer.sv
// 8-bit period timer with postscaler, modes and register slave
`timescale 1ns/1ps
`default_nettype none
`include "ptp_regs.svh"

module ptp_timer (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // axi4-lite write channels
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // axi4-lite read channels
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [7:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // external reset/gate sources
  input wire logic [`PTP_SRC_N-1:0] i_ext_src,
  input wire logic i_debug_freeze,
  // outputs to other peripherals
  output logic o_period_pulse_out,
  output logic [7:0] o_count_value,
  output logic [7:0] o_period_value,
  output logic o_timer_tick,
  output logic o_period_match,
  // interrupt
  output logic o_irq
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic aw_rdy_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic ar_rdy_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] count_reg;
  logic [7:0] period_reg;
  logic run_enable_reg;
  logic [2:0] psc_sel_reg;
  logic [4:0] postscale_select_reg;
  logic [4:0] mode_reg;
  logic [2:0] src_sel_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [4:0] post_cnt_reg;
  logic pulse_reg;
  logic match_reg;
  logic irq_reg;
  ptp_pkg::ptp_state_type state_reg;
  ptp_pkg::ptp_state_type state_next;
  logic tick;
  ptp_pkg::ptp_trig_type trig;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  wire wr_fire = aw_rdy_reg & i_s_axi_awvalid & i_s_axi_wvalid;
  wire wr_lane = wr_fire & i_s_axi_wstrb[0];
  wire [7:0] wd = i_s_axi_wdata[7:0];
  wire [7:0] wa = {i_s_axi_awaddr[7:2], 2'b00};
  wire wr_count = wr_lane && (wa == `PTP_OFF_COUNT);
  wire wr_period = wr_lane && (wa == `PTP_OFF_PERIOD);
  wire wr_ctrl = wr_lane && (wa == `PTP_OFF_CTRL);
  wire wr_ctrl1 = wr_lane && (wa == `PTP_OFF_CTRL1);
  wire wr_halt = wr_lane && (wa == `PTP_OFF_HALT);
  wire wr_src = wr_lane && (wa == `PTP_OFF_RSTSRC);
  wire wr_mask = wr_lane && (wa == `PTP_OFF_MASK);
  wire wr_hit = (wa <= `PTP_OFF_MASK);
  wire aw_rdy_next = ~aw_rdy_reg & ~bvalid_reg & i_s_axi_awvalid & i_s_axi_wvalid;

  wire rd_fire = ar_rdy_reg & i_s_axi_arvalid;
  wire [7:0] ra = {i_s_axi_araddr[7:2], 2'b00};
  wire rd_hit = (ra <= `PTP_OFF_MASK);
  wire rd_status = rd_fire && (ra == `PTP_OFF_STATUS);
  wire ar_rdy_next = ~ar_rdy_reg & ~rvalid_reg & i_s_axi_arvalid;
  wire [31:0] rd_data =
    (ra == `PTP_OFF_COUNT) ? {24'h00_0000, count_reg} :
    (ra == `PTP_OFF_PERIOD) ? {24'h00_0000, period_reg} :
    (ra == `PTP_OFF_CTRL) ? {24'h00_0000, run_enable_reg, psc_sel_reg, 4'h0} :
    (ra == `PTP_OFF_CTRL1) ? {27'h000_0000, postscale_select_reg} :
    (ra == `PTP_OFF_HALT) ? {27'h000_0000, mode_reg} :
    (ra == `PTP_OFF_RSTSRC) ? {29'h0000_0000, src_sel_reg} :
    (ra == `PTP_OFF_STATUS) ? {29'h0000_0000, status_reg} :
    (ra == `PTP_OFF_MASK) ? {29'h0000_0000, mask_reg} :
    `PTP_RD_ZERO;

  // --------------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------------
  // mode field split
  wire ptp_pkg::ptp_mode_type mode = ptp_pkg::ptp_mode_type'(mode_reg);
  wire fam_one = (mode.family == ptp_pkg::FAM_ONE);
  wire fam_mono = (mode.family == ptp_pkg::FAM_MONO);

  wire gate_ok = (mode.opt == ptp_pkg::OPT_GATE_HI) ? trig.level :
    (mode.opt == ptp_pkg::OPT_GATE_LO) ? ~trig.level : 1'b1;

  wire ext_edge = ((mode.opt == ptp_pkg::OPT_RST_RISE) & trig.rise) |
    ((mode.opt == ptp_pkg::OPT_RST_FALL) & trig.fall) |
    ((mode.opt == ptp_pkg::OPT_RST_EDGE) & (trig.rise | trig.fall));
  wire ext_lvl = ((mode.opt == ptp_pkg::OPT_RST_LOW) & ~trig.level) |
    ((mode.opt == ptp_pkg::OPT_RST_HIGH) & trig.level);
  wire ext_rst = run_enable_reg & (ext_edge | ext_lvl);

  // --------------------------------------------------------------------------
  // counter control
  // --------------------------------------------------------------------------
  wire running = (state_reg == ptp_pkg::ST_RUN);
  wire counting = running & tick & gate_ok & ~ext_rst & ~wr_count;
  wire match = counting & (count_reg == period_reg);
  wire post_hit = match & (post_cnt_reg == postscale_select_reg);
  wire stop_one = match & fam_one;
  wire stop_mono = match & fam_mono;
  wire restart = (state_reg != ptp_pkg::ST_RUN) && (state_next == ptp_pkg::ST_RUN);
  wire scaler_clr = wr_count | wr_ctrl | ext_rst | restart;
  wire [2:0] events = {stop_one | stop_mono, match, post_hit};

  // monostable holds until an external event
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ptp_pkg::ST_IDLE: begin
        if (run_enable_reg) begin
          state_next = ptp_pkg::ST_RUN;
        end
      end
      ptp_pkg::ST_RUN: begin
        if (!run_enable_reg || stop_one) begin
          state_next = ptp_pkg::ST_IDLE;
        end else if (stop_mono) begin
          state_next = ptp_pkg::ST_HOLD;
        end
      end
      ptp_pkg::ST_HOLD: begin
        if (!run_enable_reg) begin
          state_next = ptp_pkg::ST_IDLE;
        end else if (ext_rst) begin
          state_next = ptp_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = ptp_pkg::ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // submodules
  // --------------------------------------------------------------------------
  ptp_prescaler u_prescaler (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(scaler_clr),
    .i_run(run_enable_reg | pulse_reg),
    .i_sel(psc_sel_reg),
    .o_tick(tick)
  );

  ptp_trigger u_trigger (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_src(i_ext_src),
    .i_sel(src_sel_reg),
    .i_freeze(i_debug_freeze),
    .o_trig(trig)
  );

  // --------------------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_rdy_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `PTP_RESP_OKAY;
    end else begin
      aw_rdy_reg <= aw_rdy_next;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `PTP_RESP_OKAY : `PTP_RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ar_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= `PTP_RD_ZERO;
      rresp_reg <= `PTP_RESP_OKAY;
    end else begin
      ar_rdy_reg <= ar_rdy_next;
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_data;
        rresp_reg <= rd_hit ? `PTP_RESP_OKAY : `PTP_RESP_SLVERR;
      end else if (i_s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  // period resets to all ones
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      period_reg <= `PTP_RST_PERIOD;
      psc_sel_reg <= `PTP_RST_PSC;
      postscale_select_reg <= `PTP_RST_POST;
      mode_reg <= `PTP_RST_MODE;
      src_sel_reg <= `PTP_RST_SRC;
      mask_reg <= `PTP_RST_EVT;
    end else begin
      if (wr_period) period_reg <= wd;
      if (wr_ctrl) psc_sel_reg <= wd[`PTP_CTRL_PSC_HI:`PTP_CTRL_PSC_LO];
      if (wr_ctrl1) postscale_select_reg <= wd[4:0];
      if (wr_halt) mode_reg <= wd[4:0];
      if (wr_src) src_sel_reg <= wd[2:0];
      if (wr_mask) mask_reg <= wd[2:0];
    end
  end

  // hardware clears run enable, software write wins
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      run_enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      run_enable_reg <= wd[`PTP_CTRL_RUN_BIT];
    end else if (stop_one) begin
      run_enable_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // count, postscaler and pulse
  // --------------------------------------------------------------------------
  // control writes never touch the count
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= `PTP_RST_COUNT;
    end else if (wr_count) begin
      count_reg <= wd;
    end else if (ext_rst || match) begin
      count_reg <= `PTP_RST_COUNT;
    end else if (counting) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // pulse lasts until the next tick
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      post_cnt_reg <= `PTP_RST_POST;
      pulse_reg <= 1'b0;
    end else begin
      if (scaler_clr || post_hit) begin
        post_cnt_reg <= `PTP_RST_POST;
      end else if (match) begin
        post_cnt_reg <= post_cnt_reg + 5'h01;
      end
      if (post_hit) begin
        pulse_reg <= 1'b1;
      end else if (tick) begin
        pulse_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ptp_pkg::ST_IDLE;
      match_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      match_reg <= match;
    end
  end

  // --------------------------------------------------------------------------
  // interrupt
  // --------------------------------------------------------------------------
  // new events win over the read clear
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      status_reg <= `PTP_RST_EVT;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= (rd_status ? `PTP_RST_EVT : status_reg) | events;
      irq_reg <= |(((rd_status ? `PTP_RST_EVT : status_reg) | events) & mask_reg);
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign o_s_axi_awready = aw_rdy_reg;
  assign o_s_axi_wready = aw_rdy_reg;
  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;
  assign o_s_axi_arready = ar_rdy_reg;
  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rdata = rdata_reg;
  assign o_s_axi_rresp = rresp_reg;
  // exports to converter, shutdown and pwm logic
  assign o_period_pulse_out = pulse_reg;
  assign o_count_value = count_reg;
  assign o_period_value = period_reg;
  assign o_timer_tick = tick;
  assign o_period_match = match_reg;
  assign o_irq = irq_reg;

endmodule
`default_nettype wire

//--- test/ptp_timer_properties.sv
// assertion checker bound to the period timer ports
`timescale 1ns/1ps
`default_nettype none

module ptp_timer_checker (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // register bus
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata,
  // timer outputs
  input wire logic o_period_pulse_out,
  input wire logic [7:0] o_count_value,
  input wire logic [7:0] o_period_value,
  input wire logic o_period_match
);
  wire wr_hs = i_s_axi_awvalid && i_s_axi_wvalid && o_s_axi_awready;
  wire rd_hs = i_s_axi_arvalid && o_s_axi_arready;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_count_step;
    $changed(o_count_value) && !$past(wr_hs) |-> o_count_value == 8'h00 ||
      (o_count_value == 8'($past(o_count_value) + 8'h01) && $past(o_count_value) != $past(o_period_value));
  endproperty
  a_count_step: assert property (p_count_step) else $error("count left its step");

  property p_match_zero;
    o_period_match && !$past(wr_hs) |-> o_count_value == 8'h00;
  endproperty
  a_match_zero: assert property (p_match_zero) else $error("match without wrap");

  property p_pulse_cause;
    $rose(o_period_pulse_out) |-> o_period_match || $past(o_period_match);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without match");

  property p_reset_vals;
    $fell(i_rst) |-> o_period_value == 8'hFF && o_count_value == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_b_answer;
    wr_hs |-> o_s_axi_wready ##1 o_s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("late write answer");

  property p_b_hold;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");

  property p_r_answer;
    rd_hs |=> o_s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("late read answer");

  property p_r_hold;
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
endmodule

bind ptp_timer ptp_timer_checker u_ptp_timer_checker (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_s_axi_awvalid(i_s_axi_awvalid),
  .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready), .o_s_axi_bresp(o_s_axi_bresp),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid),
  .i_s_axi_rready(i_s_axi_rready), .o_s_axi_rdata(o_s_axi_rdata), .o_period_pulse_out(o_period_pulse_out),
  .o_count_value(o_count_value), .o_period_value(o_period_value), .o_period_match(o_period_match));
`default_nettype wire

//--- test/ptp_src_model.sv
// behavioural model of the external reset and gate source
`timescale 1ns/1ps
`default_nettype none

module ptp_src_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // request from the bench
  input wire logic [2:0] i_sel,
  input wire logic i_want,
  // source lines
  output logic [7:0] o_src
);
  logic level_reg;
  logic [3:0] gap_reg;
  logic [7:0] noise_reg;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      level_reg <= 1'b0;
      gap_reg <= 4'h0;
      noise_reg <= 8'h5A;
    end else begin
      noise_reg <= ~noise_reg;
      if (i_want != level_reg && gap_reg >= 4'h6) begin
        level_reg <= i_want;
        gap_reg <= 4'h0;
      end else if (gap_reg != 4'hF) begin
        gap_reg <= gap_reg + 4'h1;
      end
    end
  end

  // unselected lines toggle every cycle so a wrong pick shows
  assign o_src = (noise_reg & ~(8'h01 << i_sel)) | ({7'h00, level_reg} << i_sel);
endmodule
`default_nettype wire

//--- test/ptp_timer_tb_top.sv
// self-checking bench for the period timer
`timescale 1ns/1ps
`default_nettype none
`include "ptp_regs.svh"

module ptp_timer_tb_top;
  logic i_core_clk = 1'b0, i_rst = 1'b1, freeze = 1'b0, want = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, d, d1;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, pulse, match, tick, irq;
  logic pulse_prev = 1'b0;
  logic [7:0] count, period, src;
  int err_total, checks_done, match_cnt, pulse_cnt, tick_cnt, cyc, m, p, q, t0;

  ptp_timer u_ptp_timer (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .i_ext_src(src),
    .i_debug_freeze(freeze), .o_period_pulse_out(pulse), .o_count_value(count), .o_period_value(period),
    .o_timer_tick(tick), .o_period_match(match), .o_irq(irq));
  ptp_src_model u_ptp_src_model (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_sel(3'h2), .i_want(want), .o_src(src));

  initial begin
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    pulse_prev <= pulse;
    if (match) match_cnt <= match_cnt + 1;
    if (tick) tick_cnt <= tick_cnt + 1;
    if (pulse && !pulse_prev) pulse_cnt <= pulse_cnt + 1;
  end

  // ------------------
  // shared tasks
  // ------------------
  task automatic results;
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic await(ref logic s);
    int i;
    i = 0;
    do begin
      @(posedge i_core_clk);
      i++;
    end while (s !== 1'b1 && i < 3000);
    if (s !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: handshake timed out", $time);
      results;
    end
  endtask

  task automatic wait_match(input int n);
    int i;
    for (i = 0; i < 3000 && match_cnt < n; i++) @(posedge i_core_clk);
    if (match_cnt < n) begin
      err_total++;
      $display("wrong value at %0t: no period match", $time);
      results;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= v;
    await(awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    // one cycle without bready so a waiting answer has to stand
    @(posedge i_core_clk);
    bready <= 1'b1;
    await(bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = 2'h0);
    arvalid <= 1'b1;
    araddr <= a;
    await(arready);
    arvalid <= 1'b0;
    @(posedge i_core_clk);
    rready <= 1'b1;
    await(rvalid);
    rready <= 1'b0;
    v = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // ------------------
  // scenarios
  // ------------------
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    rd(`PTP_OFF_COUNT, d);
    chk(d, 32'h0000_0000);
    rd(`PTP_OFF_PERIOD, d);
    chk(d, 32'h0000_00FF);
    rd(8'hFC, d, `PTP_RESP_SLVERR);
    chk(d, `PTP_RD_ZERO);
    wr(8'h40, 32'h0000_00AA, `PTP_RESP_SLVERR);
    // free running, tick every 2 clocks, pulse every 2 matches
    wr(`PTP_OFF_CTRL1, 32'h0000_0001);
    wr(`PTP_OFF_PERIOD, 32'h0000_0003);
    m = match_cnt;
    p = pulse_cnt;
    wr(`PTP_OFF_CTRL, 32'h0000_0090);
    wait_match(m + 1);
    t0 = cyc;
    q = tick_cnt;
    chk({31'h0, irq}, 32'h0000_0000);
    wait_match(m + 8);
    chk(cyc - t0, 56);
    chk(tick_cnt - q, 28);
    step(4);
    chk(pulse_cnt - p, 4);
    wr(`PTP_OFF_CTRL, 32'h0000_0000);
    wr(`PTP_OFF_MASK, 32'h0000_0007);
    step(3);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(`PTP_OFF_STATUS, d);
    chk(d, 32'h0000_0003);
    step(3);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`PTP_OFF_COUNT, 32'h0000_0005);
    wr(`PTP_OFF_CTRL, 32'h0000_0000);
    rd(`PTP_OFF_COUNT, d);
    chk(d, 32'h0000_0005);
    chk({24'h00_0000, count}, 32'h0000_0005);
    rd(`PTP_OFF_PERIOD, d);
    chk(d, 32'h0000_0003);
    chk({24'h00_0000, period}, 32'h0000_0003);
    // one-shot, run twice
    wr(`PTP_OFF_HALT, 32'h0000_0008);
    wr(`PTP_OFF_COUNT, 32'h0000_0000);
    wr(`PTP_OFF_PERIOD, 32'h0000_0004);
    m = match_cnt;
    p = pulse_cnt;
    wr(`PTP_OFF_CTRL, 32'h0000_0080);
    wait_match(m + 1);
    step(12);
    rd(`PTP_OFF_CTRL, d);
    chk(d, 32'h0000_0000);
    rd(`PTP_OFF_STATUS, d);
    chk(d, 32'h0000_0006);
    wr(`PTP_OFF_CTRL, 32'h0000_0080);
    wait_match(m + 2);
    step(12);
    chk(match_cnt - m, 2);
    chk(pulse_cnt - p, 0);
    // monostable restarted by a rising source edge
    wr(`PTP_OFF_HALT, 32'h0000_0013);
    wr(`PTP_OFF_RSTSRC, 32'h0000_0002);
    m = match_cnt;
    wr(`PTP_OFF_CTRL, 32'h0000_0080);
    wait_match(m + 1);
    step(12);
    rd(`PTP_OFF_CTRL, d);
    chk(d, 32'h0000_0080);
    chk(match_cnt - m, 1);
    want <= 1'b1;
    wait_match(m + 2);
    want <= 1'b0;
    // gate high
    wr(`PTP_OFF_CTRL, 32'h0000_0000);
    wr(`PTP_OFF_HALT, 32'h0000_0001);
    wr(`PTP_OFF_COUNT, 32'h0000_0000);
    wr(`PTP_OFF_PERIOD, 32'h0000_00FF);
    wr(`PTP_OFF_CTRL, 32'h0000_0080);
    step(20);
    rd(`PTP_OFF_COUNT, d);
    chk(d, 32'h0000_0000);
    want <= 1'b1;
    step(20);
    rd(`PTP_OFF_COUNT, d);
    chk({31'h0, d != 32'h0000_0000}, 32'h0000_0001);
    want <= 1'b0;
    step(12);
    rd(`PTP_OFF_COUNT, d1);
    step(10);
    rd(`PTP_OFF_COUNT, d);
    chk(d, d1);
    // reset while high, then no reset under debug freeze
    wr(`PTP_OFF_HALT, 32'h0000_0007);
    want <= 1'b1;
    step(12);
    rd(`PTP_OFF_COUNT, d);
    chk(d, 32'h0000_0000);
    want <= 1'b0;
    step(12);
    freeze <= 1'b1;
    want <= 1'b1;
    step(20);
    rd(`PTP_OFF_COUNT, d);
    chk({31'h0, d != 32'h0000_0000}, 32'h0000_0001);
    freeze <= 1'b0;
    // gate low: held while the source is high, runs once it drops
    wr(`PTP_OFF_HALT, 32'h0000_0002);
    step(4);
    rd(`PTP_OFF_COUNT, d1);
    step(10);
    rd(`PTP_OFF_COUNT, d);
    chk(d, d1);
    want <= 1'b0;
    step(12);
    rd(`PTP_OFF_COUNT, d);
    chk({31'h0, d != d1}, 32'h0000_0001);
    results;
  end
endmodule
`default_nettype wire
